// File: fpas_pkg.sv
/*
  Shared constants and types for the host-side flash auto select controller.
  Assumes a 10 MHz controller clock and an asynchronous parallel flash device.
*/
package fpas_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_ACC_NS = 100;
  localparam int unsigned T_WP_NS = 50;
  localparam int unsigned T_RP_NS = 500;
  localparam int unsigned T_RH_NS = 200;

  function automatic int unsigned fpas_min_cycles(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : fpas_min_cycles

  localparam int unsigned ACC_CYC = fpas_min_cycles(T_ACC_NS);
  localparam int unsigned WP_CYC = fpas_min_cycles(T_WP_NS);
  localparam int unsigned RP_CYC = fpas_min_cycles(T_RP_NS);
  localparam int unsigned RH_CYC = fpas_min_cycles(T_RH_NS);

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BLK_LSB = 12;

  localparam logic [3:0] ID_LOW_MANUF = 4'h0;
  localparam logic [3:0] ID_LOW_DEV1 = 4'h1;
  localparam logic [3:0] ID_LOW_DEV2 = 4'he;
  localparam logic [3:0] ID_LOW_DEV3 = 4'hf;
  localparam logic [3:0] EXT_IND_LOW = 4'h3;
  localparam logic [3:0] BLK_STAT_LOW = 4'h2;

  localparam logic [15:0] BLK_PROT_WORD = 16'h0001;
  localparam logic [15:0] BLK_UNPROT_WORD = 16'h0000;
  localparam int EXT_FACT_BIT = 7;
  localparam int EXT_CUST_BIT = 6;
  localparam int EXT_RESV_BIT = 5;
  localparam int EXT_WP_LSB = 3;
  localparam logic [1:0] EXT_WP_OUTER = 2'h0;
  localparam logic [1:0] EXT_WP_NONE = 2'h3;

  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [7:0] CNT_RESET = 8'h00;

  typedef enum logic [2:0] {
    FPAS_OP_READ = 3'h0,
    FPAS_OP_WRITE = 3'h1,
    FPAS_OP_ID = 3'h2,
    FPAS_OP_EXT_IND = 3'h3,
    FPAS_OP_BLK_STAT = 3'h4,
    FPAS_OP_RESET = 3'h5
  } fpas_op_t;

  typedef enum logic [2:0] {
    FPAS_ST_IDLE = 3'b000,
    FPAS_ST_SETUP = 3'b001,
    FPAS_ST_STROBE = 3'b011,
    FPAS_ST_CAPTURE = 3'b010,
    FPAS_ST_RECOVER = 3'b110,
    FPAS_ST_RST_LOW = 3'b111,
    FPAS_ST_RST_HIGH = 3'b101
  } fpas_state_t;

endpackage : fpas_pkg

// File: fpas_rsp_if.sv
/*
  Carrier between the controller and its answer decoder.
  Assumes both ends run combinationally inside one clock domain.
*/
`timescale 1ns/10ps
interface fpas_rsp_if
  import fpas_pkg::*;
;
  logic [15:0] word;
  fpas_op_t op;
  logic prot;
  logic fact;
  logic cust;
  logic resv;
  logic wp_outer;
  logic bad;
  modport src (output word, output op, input prot, input fact, input cust, input resv, input wp_outer, input bad);
  modport dec (input word, input op, output prot, output fact, output cust, output resv, output wp_outer, output bad);
endinterface : fpas_rsp_if

// File: fpas_decode.sv
/*
  Decodes a word read in auto select mode into protection fields.
  Assumes the word is stable while the controller captures it.
*/
`timescale 1ns/10ps
module fpas_decode
  import fpas_pkg::*;
(
  fpas_rsp_if.dec rsp
);

  logic [1:0] wp_field;

  always_comb begin
    wp_field = rsp.word[EXT_WP_LSB +: 2];
    rsp.prot = 1'b0;
    rsp.fact = 1'b0;
    rsp.cust = 1'b0;
    rsp.resv = 1'b0;
    rsp.wp_outer = 1'b0;
    rsp.bad = 1'b0;
    case (rsp.op)
      FPAS_OP_BLK_STAT: begin
        rsp.prot = (rsp.word == BLK_PROT_WORD);
        rsp.bad = (rsp.word != BLK_PROT_WORD) && (rsp.word != BLK_UNPROT_WORD);
      end
      FPAS_OP_EXT_IND: begin
        rsp.fact = rsp.word[EXT_FACT_BIT];
        rsp.cust = rsp.word[EXT_CUST_BIT];
        rsp.resv = rsp.word[EXT_RESV_BIT];
        rsp.wp_outer = (wp_field == EXT_WP_OUTER);
        rsp.bad = (rsp.word[15:8] != 8'h00) || (rsp.word[2:0] != 3'h0)
          || ((wp_field != EXT_WP_OUTER) && (wp_field != EXT_WP_NONE));
      end
      default: begin
        rsp.bad = 1'b0;
      end
    endcase
  end

endmodule : fpas_decode

// File: fpas_ctrl.sv
/*
  Host-side controller that drives a parallel flash through its pins: bus
  reads and writes, auto select identification, block protection and extended
  block indicator reads, hardware reset and the write protect pin.
  Assumes device inputs are synchronous to i_mclk and the data bus resolves
  from o_dq_out and o_dq_oe outside this module.
*/
`timescale 1ns/10ps
module fpas_ctrl
  import fpas_pkg::*;
#(
  parameter int unsigned ACC_CYCLES = ACC_CYC,
  parameter int unsigned WP_CYCLES = WP_CYC,
  parameter int unsigned RP_CYCLES = RP_CYC,
  parameter int unsigned RH_CYCLES = RH_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire fpas_op_t i_cmd_op,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic i_wp_hold,
  input wire logic [15:0] i_dq_in,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  output logic o_rsp_protected,
  output logic o_rsp_factory_locked,
  output logic o_rsp_cust_locked,
  output logic o_rsp_reserved,
  output logic o_rsp_wp_outer,
  output logic o_rsp_bad,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_hw_reset_n,
  output logic o_accel_protect_pin,
  output logic o_a9_vid,
  output logic [23:0] o_addr,
  output logic [15:0] o_dq_out,
  output logic o_dq_oe
);

  function automatic logic [23:0] fpas_as_addr(input logic [23:0] base, input logic [3:0] low);
    return {base[23:BLK_LSB], 8'h00, low};
  endfunction : fpas_as_addr

  function automatic logic [7:0] fpas_cnt(input int unsigned n);
    return 8'((n < 1) ? 0 : n - 1);
  endfunction : fpas_cnt

  fpas_state_t state_reg, state_next;
  fpas_op_t op_reg, op_next;
  logic [7:0] cnt_reg, cnt_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic rst_n_reg, rst_n_next;
  logic wp_reg, wp_next;
  logic vid_reg, vid_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next;
  logic ready_reg, ready_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [15:0] rsp_data_reg, rsp_data_next;
  logic [5:0] flags_reg, flags_next;
  logic [3:0] id_low;

  fpas_rsp_if rsp ();

  fpas_decode u_decode (
    .rsp(rsp)
  );

  assign rsp.word = i_dq_in;
  assign rsp.op = op_reg;

  always_comb begin
    case (i_cmd_addr[1:0])
      2'h0: id_low = ID_LOW_MANUF;
      2'h1: id_low = ID_LOW_DEV1;
      2'h2: id_low = ID_LOW_DEV2;
      default: id_low = ID_LOW_DEV3;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    rst_n_next = rst_n_reg;
    vid_next = vid_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    ready_next = ready_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    flags_next = flags_reg;
    wp_next = ~i_wp_hold;
    if (cnt_reg != CNT_RESET) begin
      cnt_next = cnt_reg - 8'h01;
    end
    case (state_reg)
      FPAS_ST_IDLE: begin
        if (i_cmd_valid && ready_reg) begin
          ready_next = 1'b0;
          op_next = i_cmd_op;
          vid_next = 1'b0;
          addr_next = i_cmd_addr;
          state_next = FPAS_ST_SETUP;
          case (i_cmd_op)
            FPAS_OP_WRITE: begin
              dq_next = i_cmd_wdata;
              dq_oe_next = 1'b1;
            end
            FPAS_OP_ID: begin
              vid_next = 1'b1;
              addr_next = fpas_as_addr(i_cmd_addr, id_low);
            end
            FPAS_OP_EXT_IND: begin
              vid_next = 1'b1;
              addr_next = fpas_as_addr(i_cmd_addr, EXT_IND_LOW);
            end
            FPAS_OP_BLK_STAT: begin
              vid_next = 1'b1;
              addr_next = fpas_as_addr(i_cmd_addr, BLK_STAT_LOW);
            end
            FPAS_OP_RESET: begin
              rst_n_next = 1'b0;
              cnt_next = fpas_cnt(RP_CYCLES);
              state_next = FPAS_ST_RST_LOW;
            end
            default: begin
              dq_oe_next = 1'b0;
            end
          endcase
        end
      end
      FPAS_ST_SETUP: begin
        ce_n_next = 1'b0;
        if (op_reg == FPAS_OP_WRITE) begin
          oe_n_next = 1'b1;
          we_n_next = 1'b0;
          cnt_next = fpas_cnt(WP_CYCLES);
        end else begin
          we_n_next = 1'b1;
          oe_n_next = 1'b0;
          cnt_next = fpas_cnt(ACC_CYCLES);
        end
        state_next = FPAS_ST_STROBE;
      end
      FPAS_ST_STROBE: begin
        if (cnt_reg == CNT_RESET) begin
          state_next = FPAS_ST_CAPTURE;
        end
      end
      FPAS_ST_CAPTURE: begin
        if (op_reg == FPAS_OP_WRITE) begin
          we_n_next = 1'b1;
        end else begin
          rsp_data_next = i_dq_in;
          flags_next = {rsp.prot, rsp.fact, rsp.cust, rsp.resv, rsp.wp_outer, rsp.bad};
          oe_n_next = 1'b1;
        end
        state_next = FPAS_ST_RECOVER;
      end
      FPAS_ST_RECOVER: begin
        ce_n_next = 1'b1;
        dq_oe_next = 1'b0;
        vid_next = 1'b0;
        rsp_valid_next = 1'b1;
        ready_next = 1'b1;
        state_next = FPAS_ST_IDLE;
      end
      FPAS_ST_RST_LOW: begin
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        dq_oe_next = 1'b0;
        if (cnt_reg == CNT_RESET) begin
          rst_n_next = 1'b1;
          cnt_next = fpas_cnt(RH_CYCLES);
          state_next = FPAS_ST_RST_HIGH;
        end
      end
      FPAS_ST_RST_HIGH: begin
        if (cnt_reg == CNT_RESET) begin
          rsp_valid_next = 1'b1;
          ready_next = 1'b1;
          state_next = FPAS_ST_IDLE;
        end
      end
      default: begin
        state_next = FPAS_ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= FPAS_ST_IDLE;
      op_reg <= FPAS_OP_READ;
      cnt_reg <= CNT_RESET;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      rst_n_reg <= 1'b1;
      wp_reg <= 1'b1;
      vid_reg <= 1'b0;
      addr_reg <= ADDR_RESET;
      dq_reg <= DATA_RESET;
      dq_oe_reg <= 1'b0;
      ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= DATA_RESET;
      flags_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      rst_n_reg <= rst_n_next;
      wp_reg <= wp_next;
      vid_reg <= vid_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      flags_reg <= flags_next;
    end
  end

  assign o_cmd_ready = ready_reg;
  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_data = rsp_data_reg;
  assign o_rsp_protected = flags_reg[5];
  assign o_rsp_factory_locked = flags_reg[4];
  assign o_rsp_cust_locked = flags_reg[3];
  assign o_rsp_reserved = flags_reg[2];
  assign o_rsp_wp_outer = flags_reg[1];
  assign o_rsp_bad = flags_reg[0];
  assign o_ce_n = ce_n_reg;
  assign o_oe_n = oe_n_reg;
  assign o_we_n = we_n_reg;
  assign o_hw_reset_n = rst_n_reg;
  assign o_accel_protect_pin = wp_reg;
  assign o_a9_vid = vid_reg;
  assign o_addr = addr_reg;
  assign o_dq_out = dq_reg;
  assign o_dq_oe = dq_oe_reg;

endmodule : fpas_ctrl

// File: fpas_ctrl_assertions.sv
/* Pin timing and response word checks for fpas_ctrl. Assumes it is bound to fpas_ctrl. */
`timescale 1ns/10ps
module fpas_ctrl_chk
  import fpas_pkg::*;
#(
  parameter int unsigned RP_CYCLES = 5
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire fpas_op_t i_cmd_op,
  input wire logic i_wp_hold,
  input wire logic o_cmd_ready,
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_data,
  input wire logic o_rsp_protected,
  input wire logic o_rsp_factory_locked,
  input wire logic o_rsp_bad,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic o_hw_reset_n,
  input wire logic o_accel_protect_pin,
  input wire logic o_a9_vid,
  input wire logic [23:0] o_addr,
  input wire logic o_dq_oe
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  chk_write_strobes: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_hw_reset_n && o_dq_oe)
    else $error("write strobes wrong");
  chk_read_strobes: assert property (!o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe)
    else $error("read strobes wrong");
  chk_drive_write_only: assert property (o_dq_oe |-> o_oe_n && o_hw_reset_n)
    else $error("data driven outside a write");
  chk_answer_time: assert property (i_cmd_valid && o_cmd_ready && i_cmd_op != FPAS_OP_RESET |-> ##[4:5] o_rsp_valid)
    else $error("answer late");
  chk_reset_pulse: assert property ($fell(o_hw_reset_n) |-> !o_hw_reset_n [*5])
    else $error("reset pulse short");
  chk_auto_addr: assert property (!o_oe_n && o_a9_vid |-> o_addr[11:4] == 8'h00)
    else $error("auto select address wrong");
  chk_blk_word: assert property (o_rsp_valid && o_rsp_protected |-> o_rsp_data == BLK_PROT_WORD)
    else $error("protected word wrong");
  chk_ext_word: assert property (o_rsp_valid && o_rsp_factory_locked && !o_rsp_bad |-> o_rsp_data[15:7] == 9'h001)
    else $error("indicator word wrong");
  chk_accel_pin: assert property (1'b1 |=> o_accel_protect_pin == !$past(i_wp_hold))
    else $error("write protect pin wrong");
  cover property (o_rsp_valid && o_rsp_protected);
  cover property (o_rsp_valid && o_rsp_factory_locked);
  cover property ($fell(o_hw_reset_n));
endmodule : fpas_ctrl_chk
bind fpas_ctrl fpas_ctrl_chk #(.RP_CYCLES(RP_CYCLES)) fpas_ctrl_chk_inst (
  .i_mclk(i_mclk),
  .i_reset_n(i_reset_n),
  .i_cmd_valid(i_cmd_valid),
  .i_cmd_op(i_cmd_op),
  .i_wp_hold(i_wp_hold),
  .o_cmd_ready(o_cmd_ready),
  .o_rsp_valid(o_rsp_valid),
  .o_rsp_data(o_rsp_data),
  .o_rsp_protected(o_rsp_protected),
  .o_rsp_factory_locked(o_rsp_factory_locked),
  .o_rsp_bad(o_rsp_bad),
  .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n),
  .o_we_n(o_we_n),
  .o_hw_reset_n(o_hw_reset_n),
  .o_accel_protect_pin(o_accel_protect_pin),
  .o_a9_vid(o_a9_vid),
  .o_addr(o_addr),
  .o_dq_oe(o_dq_oe)
);

// File: fpas_dev_model.sv
/* Behavioural parallel flash device. Assumes its pins come from fpas_ctrl. */
`timescale 1ns/10ps
module fpas_dev_model #(
  parameter logic [63:0] ID_CODES = 64'h00a1_1b01_1b02_1b03,
  parameter logic [11:0] PROT_BLK = 12'h005
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_rst_n,
  input wire logic i_wp_n,
  input wire logic i_vid,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe
);
  logic [15:0] store_reg = 16'h1234;
  logic [11:0] blk;
  logic prot;
  assign blk = i_addr[23:12];
  // Mode stays non-volatile since no lock bit is ever programmed.
  assign prot = (blk == PROT_BLK) || (!i_wp_n && (blk < 12'h002 || blk > 12'hffd));
  assign o_dq_oe = i_rst_n && !i_ce_n && !i_oe_n && i_we_n;
  always_comb begin
    o_dq = store_reg;
    if (i_vid && i_addr[7:4] == 4'h0) begin
      case (i_addr[3:0])
        4'h0: o_dq = ID_CODES[63:48];
        4'h1: o_dq = ID_CODES[47:32];
        4'he: o_dq = ID_CODES[31:16];
        4'hf: o_dq = ID_CODES[15:0];
        4'h3: o_dq = i_addr[22] ? 16'h0080 : (i_addr[23] ? 16'h0109 : 16'h0078);
        4'h2: o_dq = {15'h0000, prot};
        default: o_dq = 16'hffff;
      endcase
    end
  end
  always @(posedge i_we_n) begin
    if (i_rst_n && !i_ce_n && !prot) begin
      store_reg <= i_dq;
    end
  end
endmodule : fpas_dev_model

// File: tb_flash_protect_autoselect.sv
/* Self-checking bench for fpas_ctrl. Assumes the device model on its pins. */
`timescale 1ns/10ps
module tb_flash_protect_autoselect
  import fpas_pkg::*;
;
  localparam logic [63:0] IDS = 64'h00a1_1b01_1b02_1b03; // Arbitrary identity values.
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_cmd_valid = 1'b0;
  fpas_op_t i_cmd_op = FPAS_OP_READ;
  logic [23:0] i_cmd_addr = 24'h000000;
  logic [15:0] i_cmd_wdata = 16'h0000;
  logic i_wp_hold = 1'b0;
  logic [15:0] i_dq_in, dev_dq, o_rsp_data, o_dq_out;
  logic [15:0] last_reg = 16'h0000;
  logic [23:0] o_addr;
  logic o_cmd_ready, o_rsp_valid, o_rsp_protected, o_rsp_factory_locked, o_rsp_cust_locked;
  logic o_rsp_reserved, o_rsp_wp_outer, o_rsp_bad, o_ce_n, o_oe_n, o_we_n, o_hw_reset_n;
  logic o_accel_protect_pin, o_a9_vid, o_dq_oe, dev_oe;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  fpas_ctrl fpas_ctrl_inst (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op),
    .i_cmd_addr(i_cmd_addr),
    .i_cmd_wdata(i_cmd_wdata),
    .i_wp_hold(i_wp_hold),
    .i_dq_in(i_dq_in),
    .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data),
    .o_rsp_protected(o_rsp_protected),
    .o_rsp_factory_locked(o_rsp_factory_locked),
    .o_rsp_cust_locked(o_rsp_cust_locked),
    .o_rsp_reserved(o_rsp_reserved),
    .o_rsp_wp_outer(o_rsp_wp_outer),
    .o_rsp_bad(o_rsp_bad),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_hw_reset_n(o_hw_reset_n),
    .o_accel_protect_pin(o_accel_protect_pin),
    .o_a9_vid(o_a9_vid),
    .o_addr(o_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe)
  );
  fpas_dev_model #(.ID_CODES(IDS), .PROT_BLK(12'h005)) fpas_dev_model_inst (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n),
    .i_we_n(o_we_n), .i_rst_n(o_hw_reset_n), .i_wp_n(o_accel_protect_pin), .i_vid(o_a9_vid), .i_addr(o_addr),
    .i_dq(o_dq_out), .o_dq(dev_dq), .o_dq_oe(dev_oe));
  // Nobody driving: the bus shows the inverse of its last value.
  assign i_dq_in = o_dq_oe ? o_dq_out : (dev_oe ? dev_dq : ~last_reg);
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    last_reg <= i_dq_in;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input fpas_op_t op, input logic [23:0] addr, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= op;
    i_cmd_addr <= addr;
    i_cmd_wdata <= wd;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
    end while (o_rsp_valid !== 1'b1 && n < 40);
    chk({15'h0000, o_rsp_valid}, 16'h0001);
  endtask : cmd
  task automatic t_ids();
    for (int i = 0; i < 4; i++) begin
      cmd(FPAS_OP_ID, 24'(i), 16'h0000);
      chk(o_rsp_data, IDS[16 * (3 - i) +: 16]);
    end
  endtask : t_ids
  task automatic t_ext();
    cmd(FPAS_OP_EXT_IND, 24'h400000, 16'h0000);
    chk(o_rsp_data, 16'h0080);
    chk({11'h000, o_rsp_factory_locked, o_rsp_cust_locked, o_rsp_reserved, o_rsp_wp_outer, o_rsp_bad}, 16'h0012);
    cmd(FPAS_OP_EXT_IND, 24'h000000, 16'h0000);
    chk(o_rsp_data, 16'h0078);
    chk({11'h000, o_rsp_factory_locked, o_rsp_cust_locked, o_rsp_reserved, o_rsp_wp_outer, o_rsp_bad}, 16'h000c);
    cmd(FPAS_OP_EXT_IND, 24'h800000, 16'h0000);
    chk({11'h000, o_rsp_factory_locked, o_rsp_cust_locked, o_rsp_reserved, o_rsp_wp_outer, o_rsp_bad}, 16'h0001);
  endtask : t_ext
  task automatic t_blk();
    cmd(FPAS_OP_BLK_STAT, 24'h005abc, 16'h0000);
    chk({o_rsp_data[15:1], o_rsp_protected}, BLK_PROT_WORD);
    cmd(FPAS_OP_BLK_STAT, 24'h800000, 16'h0000);
    chk(o_rsp_data, BLK_UNPROT_WORD);
    @(posedge i_mclk);
    i_wp_hold <= 1'b1;
    cmd(FPAS_OP_BLK_STAT, 24'hfff000, 16'h0000);
    chk(o_rsp_data, BLK_PROT_WORD);
    chk({15'h0000, o_accel_protect_pin}, 16'h0000);
    @(posedge i_mclk);
    i_wp_hold <= 1'b0;
    cmd(FPAS_OP_BLK_STAT, 24'hfff000, 16'h0000);
    chk(o_rsp_data, BLK_UNPROT_WORD);
  endtask : t_blk
  task automatic t_rw();
    cmd(FPAS_OP_WRITE, 24'h001000, 16'h5aa5);
    chk({15'h0000, o_dq_oe}, 16'h0000);
    cmd(FPAS_OP_READ, 24'h001000, 16'h0000);
    chk(o_rsp_data, 16'h5aa5);
    cmd(FPAS_OP_WRITE, 24'h005000, 16'h0ff0);
    cmd(FPAS_OP_READ, 24'h005000, 16'h0000);
    chk(o_rsp_data, 16'h5aa5);
  endtask : t_rw
  task automatic t_reset();
    cmd(FPAS_OP_RESET, 24'h000000, 16'h0000);
    chk({15'h0000, o_hw_reset_n}, 16'h0001);
    cmd(FPAS_OP_READ, 24'h002000, 16'h0000);
    chk(o_rsp_data, 16'h5aa5);
  endtask : t_reset
  task automatic results();
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    t_ids();
    t_ext();
    t_blk();
    t_rw();
    t_reset();
    results();
  end
endmodule : tb_flash_protect_autoselect
